// file: logic/bbr_params.svh
`ifndef BBR_PARAMS_SVH
`define BBR_PARAMS_SVH
// Functional notes
// [R1] Bit-band is a build option; without it alias addresses pass untouched.
// [R2] Two bit-band targets: lowest 1MB of SRAM and of peripheral space.
// [R3] Two 32MB alias regions, each redirected to its own 1MB target.
// [R4] Alias offset = byte offset * 32 + bit number * 4; inverted here.
// [R5] Bit number field picks one of eight bits, 0 to 7, in the byte.
// [R6] SRAM alias base 0x22000000 targets bit 0 of byte 0x20000000.
// [R7] Alias read fetches target byte, returns addressed bit in the LSB.
// [R8] Alias read data is whole-word one or zero; bits 31:1 are zero.
// [R9] Alias write is a locked read-modify-write; nothing intervenes.
// [R10] Alias write uses write data bit 0 only; bits 31:1 ignored.
// [R11] Core runs on during the sequence; stalls only on a new access.
// [R12] Direct bit-band region accesses are ordinary reads and writes.
// [R13] Instruction fetches to alias addresses are not remapped.
// [R14] Unaligned spill pieces into alias space are plain byte accesses.
// [R15] Exclusive accesses to bit-band or alias regions are unsupported.
// [R16] Peripheral alias and bit-band bases are build-time parameters.

`define BBR_SRAM_ALIAS_BASE 32'h2200_0000
`define BBR_SRAM_BAND_BASE  32'h2000_0000
`define BBR_PERI_ALIAS_DFLT 32'h4200_0000
`define BBR_PERI_BAND_DFLT  32'h4000_0000
`define BBR_ALIAS_TOP       31
`define BBR_ALIAS_BOT       25
`define BBR_BAND_TOP        31
`define BBR_BAND_BOT        20
`define BBR_BYTE_TOP        24
`define BBR_BYTE_BOT        5
`define BBR_BIT_TOP         4
`define BBR_BIT_BOT         2
`define BBR_WBIT            0
`define BBR_SIZE_BYTE       2'h0
`define BBR_BYTE_ZERO       8'h00
`define BBR_WORD_ZERO       32'h0000_0000
`define BBR_HI_ZERO         31'h0000_0000
`endif

// file: logic/bbr_pkg.sv
package bbr_pkg;
   typedef enum logic [1:0] {
      BBR_IDLE = 2'h0,
      BBR_PASS = 2'h1,
      BBR_BRD  = 2'h3,
      BBR_BWR  = 2'h2
   } bbr_state_t;
endpackage

// file: logic/bbr_region_decode.sv
`include "bbr_params.svh"
module bbr_region_decode #(
   parameter logic [31:0] ALIAS_BASE = `BBR_SRAM_ALIAS_BASE,
   parameter logic [31:0] BAND_BASE  = `BBR_SRAM_BAND_BASE
) (
   input  wire logic [31:0] addr,
   output logic             alias_hit,
   output logic             band_hit,
   output logic [31:0]      tgt_addr
);
   always_comb begin
      alias_hit = addr[`BBR_ALIAS_TOP:`BBR_ALIAS_BOT] ==
                  ALIAS_BASE[`BBR_ALIAS_TOP:`BBR_ALIAS_BOT]; // R3
      band_hit  = addr[`BBR_BAND_TOP:`BBR_BAND_BOT] ==
                  BAND_BASE[`BBR_BAND_TOP:`BBR_BAND_BOT]; // R2
      tgt_addr  = {BAND_BASE[`BBR_BAND_TOP:`BBR_BAND_BOT],
                   addr[`BBR_BYTE_TOP:`BBR_BYTE_BOT]}; // R4
   end

endmodule

// file: logic/bbr_remap.sv
`include "bbr_params.svh"
module bbr_remap #(
   parameter bit          BITBAND_EN      = 1'b1,
   parameter logic [31:0] PERI_ALIAS_BASE = `BBR_PERI_ALIAS_DFLT,
   parameter logic [31:0] PERI_BAND_BASE  = `BBR_PERI_BAND_DFLT
) (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        c_req,
   input  wire logic [31:0] c_addr,
   input  wire logic        c_write,
   input  wire logic [1:0]  c_size,
   input  wire logic [31:0] c_wdata,
   input  wire logic        c_instr,
   input  wire logic        c_spill,
   input  wire logic        c_excl,
   output logic             c_ack,
   output logic             c_err,
   output logic [31:0]      c_rdata,
   output logic             b_req,
   output logic [31:0]      b_addr,
   output logic             b_write,
   output logic [1:0]       b_size,
   output logic [31:0]      b_wdata,
   output logic             b_lock,
   input  wire logic        b_done,
   input  wire logic [31:0] b_rdata
);
   bbr_pkg::bbr_state_t state_reg, state_next;
   logic        c_ack_reg,   c_ack_next;
   logic        c_err_reg,   c_err_next;
   logic [31:0] c_rdata_reg, c_rdata_next;
   logic        b_req_reg,   b_req_next;
   logic [31:0] b_addr_reg,  b_addr_next;
   logic        b_write_reg, b_write_next;
   logic [1:0]  b_size_reg,  b_size_next;
   logic [31:0] b_wdata_reg, b_wdata_next;
   logic        b_lock_reg,  b_lock_next;
   logic        op_wr_reg,   op_wr_next;
   logic [2:0]  bit_reg,     bit_next;
   logic        wbit_reg,    wbit_next;

   logic        s_alias, s_band, p_alias, p_band;
   logic [31:0] s_tgt, p_tgt;
   logic        take, is_bb, excl_bb;
   logic [7:0]  rd_byte, new_byte;

   bbr_region_decode #(
      .ALIAS_BASE (`BBR_SRAM_ALIAS_BASE),
      .BAND_BASE  (`BBR_SRAM_BAND_BASE)
   ) u_sram_dec (
      .addr      (c_addr),
      .alias_hit (s_alias),
      .band_hit  (s_band),
      .tgt_addr  (s_tgt)
   ); // R6

   bbr_region_decode #(
      .ALIAS_BASE (PERI_ALIAS_BASE),
      .BAND_BASE  (PERI_BAND_BASE)
   ) u_peri_dec (
      .addr      (c_addr),
      .alias_hit (p_alias),
      .band_hit  (p_band),
      .tgt_addr  (p_tgt)
   ); // R16

   always_comb begin
      take    = (state_reg == bbr_pkg::BBR_IDLE) && c_req &&
                !c_ack_reg && !c_err_reg;
      is_bb   = BITBAND_EN && (s_alias || p_alias) &&
                !c_instr && !c_spill && !c_excl; // R1 R13 R14
      excl_bb = BITBAND_EN && c_excl &&
                (s_alias || p_alias || s_band || p_band); // R15
      rd_byte = b_rdata[{b_addr_reg[1:0], 3'h0} +: 8];
      new_byte = rd_byte;
      new_byte[bit_reg] = wbit_reg; // R9
   end

   always_comb begin
      state_next   = state_reg;
      c_ack_next   = 1'b0;
      c_err_next   = 1'b0;
      c_rdata_next = c_rdata_reg;
      b_req_next   = b_req_reg;
      b_addr_next  = b_addr_reg;
      b_write_next = b_write_reg;
      b_size_next  = b_size_reg;
      b_wdata_next = b_wdata_reg;
      b_lock_next  = b_lock_reg;
      op_wr_next   = op_wr_reg;
      bit_next     = bit_reg;
      wbit_next    = wbit_reg;
      unique case (state_reg)
         bbr_pkg::BBR_IDLE: begin
            if (take) begin
               if (excl_bb) begin
                  c_err_next = 1'b1; // R15
               end else if (is_bb) begin
                  b_req_next   = 1'b1;
                  b_addr_next  = s_alias ? s_tgt : p_tgt; // R3
                  b_write_next = 1'b0;
                  b_size_next  = `BBR_SIZE_BYTE;
                  b_lock_next  = c_write; // R9
                  op_wr_next   = c_write;
                  bit_next     = c_addr[`BBR_BIT_TOP:`BBR_BIT_BOT]; // R5
                  wbit_next    = c_wdata[`BBR_WBIT]; // R10
                  c_ack_next   = c_write; // R11
                  state_next   = bbr_pkg::BBR_BRD;
               end else begin
                  b_req_next   = 1'b1;
                  b_addr_next  = c_addr; // R12
                  b_write_next = c_write;
                  b_size_next  = c_size;
                  b_wdata_next = c_wdata;
                  b_lock_next  = 1'b0;
                  op_wr_next   = c_write;
                  state_next   = bbr_pkg::BBR_PASS;
               end
            end
         end
         bbr_pkg::BBR_PASS: begin
            if (b_done) begin
               b_req_next   = 1'b0;
               b_write_next = 1'b0;
               c_ack_next   = 1'b1;
               c_rdata_next = op_wr_reg ? `BBR_WORD_ZERO : b_rdata;
               state_next   = bbr_pkg::BBR_IDLE;
            end
         end
         bbr_pkg::BBR_BRD: begin
            if (b_done) begin
               if (op_wr_reg) begin
                  b_write_next = 1'b1;
                  b_wdata_next = {4{new_byte}}; // R9
                  state_next   = bbr_pkg::BBR_BWR;
               end else begin
                  b_req_next   = 1'b0;
                  c_ack_next   = 1'b1;
                  c_rdata_next = {`BBR_HI_ZERO, rd_byte[bit_reg]}; // R7 R8
                  state_next   = bbr_pkg::BBR_IDLE;
               end
            end
         end
         bbr_pkg::BBR_BWR: begin
            if (b_done) begin
               b_req_next   = 1'b0;
               b_write_next = 1'b0;
               b_lock_next  = 1'b0;
               state_next   = bbr_pkg::BBR_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         state_reg   <= bbr_pkg::BBR_IDLE;
         c_ack_reg   <= 1'b0;
         c_err_reg   <= 1'b0;
         c_rdata_reg <= `BBR_WORD_ZERO;
         b_req_reg   <= 1'b0;
         b_addr_reg  <= `BBR_WORD_ZERO;
         b_write_reg <= 1'b0;
         b_size_reg  <= `BBR_SIZE_BYTE;
         b_wdata_reg <= `BBR_WORD_ZERO;
         b_lock_reg  <= 1'b0;
         op_wr_reg   <= 1'b0;
         bit_reg     <= 3'h0;
         wbit_reg    <= 1'b0;
      end else begin
         state_reg   <= state_next;
         c_ack_reg   <= c_ack_next;
         c_err_reg   <= c_err_next;
         c_rdata_reg <= c_rdata_next;
         b_req_reg   <= b_req_next;
         b_addr_reg  <= b_addr_next;
         b_write_reg <= b_write_next;
         b_size_reg  <= b_size_next;
         b_wdata_reg <= b_wdata_next;
         b_lock_reg  <= b_lock_next;
         op_wr_reg   <= op_wr_next;
         bit_reg     <= bit_next;
         wbit_reg    <= wbit_next;
      end
   end

   assign c_ack   = c_ack_reg;
   assign c_err   = c_err_reg;
   assign c_rdata = c_rdata_reg;
   assign b_req   = b_req_reg;
   assign b_addr  = b_addr_reg;
   assign b_write = b_write_reg;
   assign b_size  = b_size_reg;
   assign b_wdata = b_wdata_reg;
   assign b_lock  = b_lock_reg;

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   sequence s_rmw_read;
      state_reg == bbr_pkg::BBR_BRD && op_wr_reg && b_done;
   endsequence

   sequence s_rmw_write;
      state_reg == bbr_pkg::BBR_BWR && b_lock_reg && b_write_reg && b_req_reg;
   endsequence

   property p_rmw_locked;
      s_rmw_read |=> s_rmw_write;
   endproperty
   a_rmw_locked: assert property (p_rmw_locked) // R9
      else $error("read-modify-write not locked into its write");

   property p_lock_hold;
      state_reg == bbr_pkg::BBR_BRD && op_wr_reg |-> b_lock_reg && b_req_reg;
   endproperty
   a_lock_hold: assert property (p_lock_hold) // R9
      else $error("lock dropped during read phase");

   property p_rd_word;
      state_reg == bbr_pkg::BBR_BRD && !op_wr_reg && b_done
      |=> c_ack_reg && c_rdata_reg[31:1] == `BBR_HI_ZERO;
   endproperty
   a_rd_word: assert property (p_rd_word) // R8
      else $error("alias read data not zero in upper bits");

   property p_rd_bit;
      state_reg == bbr_pkg::BBR_BRD && !op_wr_reg && b_done
      |=> c_rdata_reg[0] ==
          $past(b_rdata[{b_addr_reg[1:0], bit_reg}]);
   endproperty
   a_rd_bit: assert property (p_rd_bit) // R7
      else $error("alias read returned wrong bit");

   property p_wr_bit;
      s_rmw_write |-> b_wdata_reg[bit_reg] == wbit_reg;
   endproperty
   a_wr_bit: assert property (p_wr_bit) // R10
      else $error("alias write put wrong value in target bit");

   property p_sram_map;
      take && is_bb && !excl_bb && s_alias
      |=> b_addr_reg[`BBR_BAND_TOP:`BBR_BAND_BOT] ==
             (`BBR_SRAM_BAND_BASE >> `BBR_BAND_BOT)
          && b_addr_reg[`BBR_BAND_BOT-1:0] ==
             $past(c_addr[`BBR_BYTE_TOP:`BBR_BYTE_BOT])
          && bit_reg == $past(c_addr[`BBR_BIT_TOP:`BBR_BIT_BOT])
          && !b_write_reg;
   endproperty
   a_sram_map: assert property (p_sram_map) // R4
      else $error("SRAM alias mapped to wrong byte or bit");

   property p_plain;
      take && !is_bb && !excl_bb
      |=> state_reg == bbr_pkg::BBR_PASS && b_addr_reg == $past(c_addr)
          && b_size_reg == $past(c_size);
   endproperty
   a_plain: assert property (p_plain) // R12
      else $error("plain access altered");

   property p_post_ack;
      take && is_bb && c_write |=> c_ack_reg ##1 !c_ack_reg;
   endproperty
   a_post_ack: assert property (p_post_ack) // R11
      else $error("alias write not acknowledged at once");

   property p_excl;
      take && excl_bb |=> c_err_reg && !b_req_reg;
   endproperty
   a_excl: assert property (p_excl) // R15
      else $error("exclusive bit-band access reached the bus");

   property p_disabled;
      !BITBAND_EN |-> state_reg != bbr_pkg::BBR_BRD &&
                      state_reg != bbr_pkg::BBR_BWR && !b_lock_reg;
   endproperty
   a_disabled: assert property (p_disabled) // R1
      else $error("bit-band sequence without the option");
endmodule

// file: dv/bbr_mem_model.sv
module bbr_mem_model (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        slow,
   input  wire logic        b_req,
   input  wire logic [31:0] b_addr,
   input  wire logic        b_write,
   input  wire logic [1:0]  b_size,
   input  wire logic [31:0] b_wdata,
   output logic             b_done,
   output logic [31:0]      b_rdata
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0]  mem [logic [31:0]];
   logic [31:0] rd_reg;
   logic [1:0]  wait_cnt;
   int          lo;
   int          hi;

   function automatic logic [7:0] rbyte(input logic [31:0] a);
      return mem.exists(a) ? mem[a] : 8'h00;
   endfunction

   // Outside the answering cycle the data lines never repeat a stale value.
   assign b_rdata = b_done ? rd_reg : ~rd_reg;

   always @(posedge clk) begin
      lo = int'(b_addr[1:0]);
      hi = lo + (1 << b_size);
      if (rst) begin
         b_done <= 1'h0;
         wait_cnt <= 2'h0;
      end else if (b_done) begin
         b_done <= 1'h0;
      end else if (b_req) begin
         if (slow && wait_cnt != 2'h3) begin
            wait_cnt <= wait_cnt + 2'h1;
         end else begin
            wait_cnt <= 2'h0;
            b_done <= 1'h1;
            for (int i = 0; i < 4; i++) begin
               rd_reg[8*i +: 8] <= rbyte({b_addr[31:2], 2'(i)});
               if (b_write && i >= lo && i < hi) begin
                  mem[{b_addr[31:2], 2'(i)}] = b_wdata[8*i +: 8];
               end
            end
         end
      end
   end
endmodule

// file: dv/tb_top.sv
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk;
   logic        rst;
   logic        c_req, c_write, c_instr, c_spill, c_excl, slow;
   logic [1:0]  c_size, b_size;
   logic [31:0] c_addr, c_wdata, c_rdata, b_addr, b_wdata, b_rdata;
   logic        c_ack, c_err, b_req, b_write, b_lock, b_done, got_err;
   logic [31:0] rd;
   logic        c_ack_o, c_err_o, b_req_o, b_write_o, b_lock_o, b_done_o;
   logic [1:0]  b_size_o;
   logic [31:0] c_rdata_o, b_addr_o, b_wdata_o, b_rdata_o, rd_off;
   logic [31:0] q_addr[$];
   logic [31:0] q_wd[$];
   logic        q_wr[$];
   logic        q_lock[$];
   int          err_total, total_checks, cyc;

   bbr_remap dut (.clk(clk), .rst(rst), .c_req(c_req), .c_addr(c_addr),
      .c_write(c_write), .c_size(c_size), .c_wdata(c_wdata),
      .c_instr(c_instr), .c_spill(c_spill), .c_excl(c_excl),
      .c_ack(c_ack), .c_err(c_err), .c_rdata(c_rdata), .b_req(b_req),
      .b_addr(b_addr), .b_write(b_write), .b_size(b_size),
      .b_wdata(b_wdata), .b_lock(b_lock), .b_done(b_done),
      .b_rdata(b_rdata));
   bbr_mem_model mem_i (.clk(clk), .rst(rst), .slow(slow), .b_req(b_req),
      .b_addr(b_addr), .b_write(b_write), .b_size(b_size),
      .b_wdata(b_wdata), .b_done(b_done), .b_rdata(b_rdata));

   // A build without bit-band shares the core side; alias accesses pass.
   bbr_remap #(.BITBAND_EN(1'b0)) dut_off (.clk(clk), .rst(rst),
      .c_req(c_req), .c_addr(c_addr), .c_write(c_write), .c_size(c_size),
      .c_wdata(c_wdata), .c_instr(c_instr), .c_spill(c_spill),
      .c_excl(c_excl), .c_ack(c_ack_o), .c_err(c_err_o),
      .c_rdata(c_rdata_o), .b_req(b_req_o), .b_addr(b_addr_o),
      .b_write(b_write_o), .b_size(b_size_o), .b_wdata(b_wdata_o),
      .b_lock(b_lock_o), .b_done(b_done_o), .b_rdata(b_rdata_o));
   bbr_mem_model mem_off (.clk(clk), .rst(rst), .slow(slow),
      .b_req(b_req_o), .b_addr(b_addr_o), .b_write(b_write_o),
      .b_size(b_size_o), .b_wdata(b_wdata_o), .b_done(b_done_o),
      .b_rdata(b_rdata_o));

   always #5 clk = ~clk;

   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (b_req === 1'h1 && b_done === 1'h1) begin
         q_addr.push_back(b_addr);
         q_wd.push_back(b_wdata);
         q_wr.push_back(b_write);
         q_lock.push_back(b_lock);
      end
      if (cyc == 5000) begin
         err_total++;
         $display("ERROR t=%0t timeout got=%h exp=%h", $time, cyc, 0);
         test_done();
      end
   end

   task chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         err_total++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // Holds the request until the edge that samples c_ack or c_err.
   task acc(input logic [31:0] a, input logic w, input logic [1:0] sz,
            input logic [31:0] wd, input logic [2:0] f);
      int n;
      @(posedge clk);
      #1;
      c_req = 1'h1;
      c_addr = a;
      c_write = w;
      c_size = sz;
      c_wdata = wd;
      {c_instr, c_spill, c_excl} = f;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (c_ack !== 1'h1 && c_err !== 1'h1 && n < 100);
      if (n == 100) begin
         err_total++;
         $display("ERROR t=%0t no answer got=%h exp=%h", $time, c_ack,
                  1'h1);
      end
      rd = c_rdata;
      rd_off = c_rdata_o;
      got_err = c_err;
      #1;
      c_req = 1'h0;
   endtask

   task qclr;
      q_addr.delete();
      q_wd.delete();
      q_wr.delete();
      q_lock.delete();
   endtask

   task t_alias_rd;
      logic [7:0] pat;
      pat = 8'ha5;
      mem_i.mem[32'h200f_ffff] = pat;
      mem_i.mem[32'h2000_0000] = 8'h80;
      acc(32'h2200_001c, 1'h0, 2'h2, 32'h0, 3'h0);
      chk(rd, 32'h1);
      for (int b = 0; b < 8; b++) begin
         qclr();
         acc(32'h23ff_ffe0 + (32'(b) << 2), 1'h0, 2'h2, 32'h0, 3'h0);
         chk(rd, {31'h0, pat[b]});
         chk(q_addr[0], 32'h200f_ffff);
      end
   endtask

   task t_alias_wr;
      mem_i.mem[32'h2000_0004] = 8'h0f;
      qclr();
      acc(32'h2200_009c, 1'h1, 2'h2, 32'h0000_0001, 3'h0);
      acc(32'h2200_0080, 1'h1, 2'h2, 32'hffff_fffe, 3'h0);
      acc(32'h2000_0004, 1'h0, 2'h2, 32'h0, 3'h0);
      chk(rd, 32'h0000_008e);
      chk({28'h0, q_wr[0], q_lock[0], q_wr[1], q_lock[1]}, 32'h7);
      chk({28'h0, q_wr[2], q_lock[2], q_wr[3], q_lock[3]}, 32'h7);
      chk({24'h0, q_wd[1][7:0]}, 32'h8f);
      chk(q_addr[1], 32'h2000_0004);
      chk({31'h0, q_lock[4]}, 32'h0);
   endtask

   task t_direct;
      slow = 1'h1;
      qclr();
      acc(32'h2000_0010, 1'h1, 2'h2, 32'hdead_beef, 3'h0);
      acc(32'h2000_0010, 1'h0, 2'h2, 32'h0, 3'h0);
      chk(rd, 32'hdead_beef);
      chk(q_addr[0], 32'h2000_0010);
      slow = 1'h0;
   endtask

   task t_peri;
      mem_i.mem[32'h4000_0003] = 8'h00;
      acc(32'h4200_0068, 1'h1, 2'h2, 32'h0000_0001, 3'h0);
      acc(32'h4200_0068, 1'h0, 2'h2, 32'h0, 3'h0);
      chk(rd, 32'h1);
      chk({24'h0, mem_i.mem[32'h4000_0003]}, 32'h4);
   endtask

   task t_plain;
      qclr();
      acc(32'h2200_0000, 1'h0, 2'h2, 32'h0, 3'h4);
      chk(q_addr[0], 32'h2200_0000);
      acc(32'h2200_0000, 1'h0, 2'h0, 32'h0, 3'h2);
      chk(q_addr[1], 32'h2200_0000);
      acc(32'h2200_0000, 1'h0, 2'h2, 32'h0, 3'h1);
      chk({31'h0, got_err}, 32'h1);
      acc(32'h2000_0000, 1'h0, 2'h2, 32'h0, 3'h1);
      chk({31'h0, got_err}, 32'h1);
      acc(32'h4000_0000, 1'h0, 2'h2, 32'h0, 3'h1);
      chk({31'h0, got_err}, 32'h1);
      chk(32'(q_addr.size()), 32'h2);
      acc(32'h3000_0000, 1'h0, 2'h2, 32'h0, 3'h1);
      chk({31'h0, got_err}, 32'h0);
   endtask

   task t_off;
      repeat (4) @(posedge clk);
      mem_off.mem[32'h2200_0000] = 8'h5a;
      acc(32'h2200_0000, 1'h0, 2'h2, 32'h0, 3'h0);
      chk(rd_off, 32'h0000_005a);
      acc(32'h2200_0004, 1'h1, 2'h2, 32'hcafe_0001, 3'h0);
      chk({24'h0, mem_off.mem[32'h2200_0007]}, 32'hca);
   endtask

   task test_done;
      $display("checks=%0d errors=%0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   initial begin
      clk = 1'h0;
      rst = 1'h1;
      {c_req, c_write, c_instr, c_spill, c_excl, slow} = 6'h0;
      c_size = 2'h0;
      c_addr = 32'h0;
      c_wdata = 32'h0;
      err_total = 0;
      total_checks = 0;
      cyc = 0;
      repeat (2) @(posedge clk);
      #1;
      rst = 1'h0;
      t_alias_rd();
      t_alias_wr();
      t_direct();
      t_peri();
      t_plain();
      t_off();
      test_done();
   end
endmodule
